// *** logic/gpt_timer_set.sv ***
// five 16-bit timers: one standalone, two pairs that can join to 32 bits
// assumes clk_i is the internal timer clock and pins are asynchronous
`timescale 1ns/1ns
`include "gpt_defines.svh"

module gpt_timer_set (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic idle_i,
  input wire logic sleep_i,
  input wire logic [4:0] ext_pin_i,
  output logic [4:0] irq_req_o,
  output logic adc_trig_o
);

  gpt_pkg::gpt_state_s q;
  gpt_pkg::gpt_state_s d;
  logic [4:0] tick;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] pre_top(input logic [1:0] sel);
    if (sel == 2'h3) begin
      pre_top = `GPT_PRE_TOP_256;
    end else if (sel == 2'h2) begin
      pre_top = `GPT_PRE_TOP_64;
    end else if (sel == 2'h1) begin
      pre_top = `GPT_PRE_TOP_8;
    end else begin
      pre_top = `GPT_PRE_TOP_1;
    end
  endfunction

  function automatic logic [15:0] ctl_mask(input int k);
    if (k == 0) begin
      ctl_mask = `GPT_MASK_STANDALONE;
    end else if (k == 1 || k == 3) begin
      ctl_mask = `GPT_MASK_LOWER;
    end else begin
      ctl_mask = `GPT_MASK_UPPER;
    end
  endfunction

  function automatic logic [15:0] wmerge(input logic [15:0] old,
                                         input logic [15:0] nw,
                                         input logic [1:0] be);
    wmerge = old;
    if (be[0]) begin
      wmerge[7:0] = nw[7:0];
    end
    if (be[1]) begin
      wmerge[15:8] = nw[15:8];
    end
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic acc;
    logic wide;
    logic cs;
    logic gate;
    logic src;
    logic asyn;
    logic run;
    logic hit;
    logic [31:0] full;
    logic [31:0] fper;
    logic [4:0] clr;
    logic [2:0] t;
    int f;
    acc = 1'b0;
    wide = 1'b0;
    cs = 1'b0;
    gate = 1'b0;
    src = 1'b0;
    asyn = 1'b0;
    run = 1'b0;
    hit = 1'b0;
    full = 32'h0;
    fper = 32'h0;
    clr = 5'h0;
    t = adr_i[6:4];
    f = 0;
    d = q;
    tick = 5'h0;
    d.s1 = ext_pin_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.trig = 1'b0;
    acc = cyc_i && stb_i && !q.ack;
    d.ack = acc;
    if (acc && we_i && adr_i == `GPT_ADR_FLAG && sel_i[0]) begin
      clr = dat_i[4:0];
    end
    // hardware sets below override this clear
    d.flag = q.flag & ~clr;
    for (int k = 0; k < `GPT_NUM_TMR; k++) begin
      wide = ((k == 1 || k == 2) && q.ctl[1][`GPT_BIT_WIDE]) ||
             ((k == 3 || k == 4) && q.ctl[3][`GPT_BIT_WIDE]);
      // upper half of a joined pair is driven by its lower half
      if (!(wide && (k == 2 || k == 4))) begin
        cs = q.ctl[k][`GPT_BIT_CSRC];
        gate = q.ctl[k][`GPT_BIT_GATE] && !cs;
        src = cs ? (q.s2[k] && !q.s3[k]) : (gate ? q.s2[k] : 1'b1);
        // unsynchronised standalone counter keeps going in sleep
        asyn = (k == 0) && cs && !q.ctl[0][`GPT_BIT_SYNC];
        run = q.ctl[k][`GPT_BIT_RUN] &&
              !(idle_i && q.ctl[k][`GPT_BIT_IDLE_HALT]) &&
              !(sleep_i && !asyn);
        f = wide ? k + 1 : k;
        if (!run) begin
          d.pre[k] = 8'h00;
        end else if (src) begin
          if (q.pre[k] >= pre_top(q.ctl[k][`GPT_BIT_PRE_HI:`GPT_BIT_PRE_LO])) begin
            d.pre[k] = 8'h00;
            tick[k] = 1'b1;
          end else begin
            d.pre[k] = q.pre[k] + 8'h01;
          end
        end
        if (run && gate && !q.s2[k] && q.s3[k]) begin
          d.flag[f] = 1'b1;
        end
        if (tick[k]) begin
          if (wide) begin
            full = {q.cnt[k + 1], q.cnt[k]};
            fper = {q.per[k + 1], q.per[k]};
            hit = (full == fper);
            full = hit ? 32'h0 : full + 32'h1;
            d.cnt[k + 1] = full[31:16];
            d.cnt[k] = full[15:0];
          end else begin
            hit = (q.cnt[k] == q.per[k]);
            d.cnt[k] = hit ? 16'h0000 : q.cnt[k] + 16'h0001;
          end
          if (hit) begin
            d.flag[f] = 1'b1;
          end
          if (hit && (k == 4 || (k == 3 && wide))) begin
            d.trig = 1'b1;
          end
        end
      end
    end
    // software writes to count and period win over counting
    if (acc) begin
      d.rdat = 32'h0;
      if (adr_i < `GPT_ADR_FLAG && adr_i[3:2] == `GPT_OFS_CON) begin
        d.rdat = {16'h0000, q.ctl[t]};
        if (we_i) begin
          d.ctl[t] = wmerge(q.ctl[t], dat_i[15:0], sel_i[1:0]) & ctl_mask(int'(t));
          // fresh prescale phase: a smaller ratio must never start above its top
          d.pre[t] = 8'h00;
        end
      end else if (adr_i < `GPT_ADR_FLAG && adr_i[3:2] == `GPT_OFS_CNT) begin
        d.rdat = {16'h0000, q.cnt[t]};
        if (we_i) begin
          d.cnt[t] = wmerge(q.cnt[t], dat_i[15:0], sel_i[1:0]);
        end
      end else if (adr_i < `GPT_ADR_FLAG && adr_i[3:2] == `GPT_OFS_PER) begin
        d.rdat = {16'h0000, q.per[t]};
        if (we_i) begin
          d.per[t] = wmerge(q.per[t], dat_i[15:0], sel_i[1:0]);
        end
      end else if (adr_i == `GPT_ADR_FLAG) begin
        d.rdat = {27'h0, q.flag};
      end else if (adr_i == `GPT_ADR_IEN) begin
        d.rdat = {27'h0, q.ien};
        if (we_i && sel_i[0]) begin
          d.ien = dat_i[4:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dat_o = q.rdat;
  assign ack_o = q.ack;
  assign irq_req_o = q.flag & q.ien;
  assign adc_trig_o = q.trig;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic bus_wr;
  assign bus_wr = cyc_i && stb_i && we_i;

  property p_stop;
    !q.ctl[0][15] && !bus_wr |=> $stable(q.cnt[0]);
  endproperty
  a_stop: assert property (p_stop) else $error("stopped timer counted");

  property p_idle;
    idle_i && q.ctl[0][13] && !bus_wr |=> $stable(q.cnt[0]);
  endproperty
  a_idle: assert property (p_idle) else $error("timer ran in idle");

  sequence s_match0;
    tick[0] && q.cnt[0] == q.per[0] && !bus_wr;
  endsequence
  property p_wrap;
    s_match0 |=> q.cnt[0] == 16'h0000 && q.flag[0];
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap or flag on match");

  property p_pre8;
    q.ctl[0][5:4] == 2'h1 |-> q.pre[0] <= 8'h07 || $changed(q.ctl[0]);
  endproperty
  a_pre8: assert property (p_pre8) else $error("prescale 8 overran");

  property p_gate;
    q.ctl[0][15] && q.ctl[0][6] && !q.ctl[0][1] && !q.s2[0] |-> !tick[0];
  endproperty
  a_gate: assert property (p_gate) else $error("gated timer ticked");

  property p_ext_rise;
    q.ctl[0][15] && q.ctl[0][1] && q.ctl[0][5:4] == 2'h0 && !idle_i && !sleep_i
      && q.s2[0] && !q.s3[0] |-> tick[0];
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("edge not counted");

  property p_carry;
    q.ctl[1][3] && tick[1] && q.cnt[1] == 16'hFFFF && q.per[2:1] != q.cnt[2:1]
      && !bus_wr |=> q.cnt[2] == $past(q.cnt[2]) + 16'h0001;
  endproperty
  a_carry: assert property (p_carry) else $error("no carry into high word");

  property p_wide_flag;
    q.ctl[1][3] && !q.flag[1] |=> !q.flag[1];
  endproperty
  a_wide_flag: assert property (p_wide_flag) else $error("lower flag set in 32-bit");

  property p_trig;
    adc_trig_o |-> $past(tick[4] || (tick[3] && q.ctl[3][3]));
  endproperty
  a_trig: assert property (p_trig) else $error("trigger without match");

  property p_ack;
    ack_o |=> !ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held two cycles");

  // ------------------------------------------------------------
  // standalone timer: counting, sleep and gate
  // ------------------------------------------------------------
  property p_count_step;
    tick[0] && q.cnt[0] != q.per[0] && !bus_wr |=> q.cnt[0] == $past(q.cnt[0]) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count skipped");

  property p_pre64;
    q.ctl[0][5:4] == 2'h2 |-> q.pre[0] <= 8'h3F || $changed(q.ctl[0]);
  endproperty
  a_pre64: assert property (p_pre64) else $error("prescale 64 overran");

  property p_stop_pre;
    !q.ctl[0][15] |=> q.pre[0] == 8'h00;
  endproperty
  a_stop_pre: assert property (p_stop_pre) else $error("prescaler kept phase");

  property p_idle_keep;
    q.ctl[0][15] && !q.ctl[0][13] && !q.ctl[0][6] && !q.ctl[0][1] && q.ctl[0][5:4] == 2'h0
      && idle_i && !sleep_i |-> tick[0];
  endproperty
  a_idle_keep: assert property (p_idle_keep) else $error("stopped in idle");

  property p_sleep_hold;
    sleep_i && !(q.ctl[0][1] && !q.ctl[0][2]) && !bus_wr |=> $stable(q.cnt[0]);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("ran in sleep");

  // only the unsynchronised pin counter may advance while asleep
  sequence s_async_edge;
    q.ctl[0][15] && q.ctl[0][1] && !q.ctl[0][2] && q.ctl[0][5:4] == 2'h0 && !idle_i;
  endsequence
  property p_sleep_async;
    s_async_edge ##0 (sleep_i && q.s2[0] && !q.s3[0]) |-> tick[0];
  endproperty
  a_sleep_async: assert property (p_sleep_async) else $error("async edge lost");

  sequence s_gate_fall;
    q.ctl[0][15] && q.ctl[0][6] && !q.ctl[0][1] && !idle_i && !sleep_i
      && q.s3[0] && !q.s2[0];
  endsequence
  property p_gate_fall;
    s_gate_fall |=> q.flag[0];
  endproperty
  a_gate_fall: assert property (p_gate_fall) else $error("gate fall not flagged");

  // ------------------------------------------------------------
  // register bus
  // ------------------------------------------------------------
  sequence s_cnt_wr0;
    cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h04 && sel_i[1:0] == 2'h3;
  endsequence
  property p_cnt_wr0;
    s_cnt_wr0 |=> q.cnt[0] == $past(dat_i[15:0]);
  endproperty
  a_cnt_wr0: assert property (p_cnt_wr0) else $error("count write lost");

  sequence s_flag_clr0;
    cyc_i && stb_i && we_i && !ack_o && adr_i == `GPT_ADR_FLAG && sel_i[0] && dat_i[0];
  endsequence
  property p_flag_clr0;
    s_flag_clr0 ##0 (!tick[0] && !(q.s3[0] && !q.s2[0])) |=> !q.flag[0];
  endproperty
  a_flag_clr0: assert property (p_flag_clr0) else $error("flag clear lost");

  property p_unmapped;
    cyc_i && stb_i && !ack_o && adr_i > `GPT_ADR_IEN |=> ack_o && dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  // ------------------------------------------------------------
  // paired timers
  // ------------------------------------------------------------
  sequence s_match1;
    q.ctl[1][3] && tick[1] && q.cnt[2:1] == q.per[2:1] && !bus_wr;
  endsequence
  property p_wrap32;
    s_match1 |=> q.cnt[2:1] == 32'h0 && q.flag[2];
  endproperty
  a_wrap32: assert property (p_wrap32) else $error("32-bit match missed");

  property p_wide_upper;
    q.ctl[1][3] |-> !tick[2];
  endproperty
  a_wide_upper: assert property (p_wide_upper) else $error("upper half ran alone");

  property p_gate_ignored;
    q.ctl[1][15] && q.ctl[1][6] && q.ctl[1][1] && q.ctl[1][5:4] == 2'h0 && !idle_i && !sleep_i
      && q.s2[1] && !q.s3[1] |-> tick[1];
  endproperty
  a_gate_ignored: assert property (p_gate_ignored) else $error("gate used with pin clock");

  property p_pair_sync;
    !q.ctl[1][2] && !q.ctl[2][2] && !q.ctl[3][2] && !q.ctl[4][2];
  endproperty
  a_pair_sync: assert property (p_pair_sync) else $error("pair took sync bit");

endmodule

// *** include/gpt_defines.svh ***
// register map, field positions, prescale tops and write masks
// assumes a 32-bit classic wishbone slave with byte addresses
`ifndef GPT_DEFINES_SVH
`define GPT_DEFINES_SVH

`define GPT_NUM_TMR 5
`define GPT_STRIDE_SH 4
`define GPT_OFS_CON 2'h0
`define GPT_OFS_CNT 2'h1
`define GPT_OFS_PER 2'h2
`define GPT_ADR_FLAG 8'h50
`define GPT_ADR_IEN 8'h54

`define GPT_BIT_RUN 15
`define GPT_BIT_IDLE_HALT 13
`define GPT_BIT_GATE 6
`define GPT_BIT_PRE_HI 5
`define GPT_BIT_PRE_LO 4
`define GPT_BIT_WIDE 3
`define GPT_BIT_SYNC 2
`define GPT_BIT_CSRC 1

`define GPT_MASK_STANDALONE 16'hA076
`define GPT_MASK_LOWER 16'hA07A
`define GPT_MASK_UPPER 16'hA072

`define GPT_PRE_TOP_1 8'h00
`define GPT_PRE_TOP_8 8'h07
`define GPT_PRE_TOP_64 8'h3F
`define GPT_PRE_TOP_256 8'hFF

`endif

// *** include/gpt_pkg.sv ***
// state type of the timer set
// assumes gpt_defines.svh for all numbers
package gpt_pkg;

  typedef struct packed {
    logic [4:0][15:0] ctl;
    logic [4:0][15:0] cnt;
    logic [4:0][15:0] per;
    logic [4:0][7:0] pre;
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] flag;
    logic [4:0] ien;
    logic ack;
    logic [31:0] rdat;
    logic trig;
  } gpt_state_s;

endpackage

// *** bench/gpt_pin_model.sv ***
// pin model: pulse train per channel, or a steady gate level
// assumes clk_i is the bench clock; pins are push-pull
`timescale 1ns/1ns
module gpt_pin_model (
  input wire logic clk_i,
  input wire logic [4:0] run_i,
  input wire logic [4:0] lvl_i,
  output logic [4:0] pin_o
);
  logic [1:0] div_q = 2'h0;
  // ---
  // pulse train
  // ---
  always_ff @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
  end
  // clock stands at the gate level outside bursts
  assign pin_o = (run_i & {5{div_q[1]}}) | (~run_i & lvl_i);
endmodule

// *** bench/tb_top.sv ***
// self-checking bench for the timer set over classic wishbone
// assumes gpt_pin_model on the pins and a 50 MHz clk_i
`timescale 1ns/1ns
`include "gpt_defines.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic ack;
  logic trig;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] r;
  logic [4:0] irq;
  logic [4:0] pin;
  logic [4:0] prun = 5'h00;
  logic [4:0] plvl = 5'h00;
  int mismatches = 0;
  int cmp_count = 0;
  int trig_n = 0;
  always #10 clk_i = ~clk_i;
  // cyc and stb share one driver: they always move together
  gpt_timer_set uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(req), .stb_i(req), .we_i(we),
    .adr_i(adr), .sel_i(4'h3), .dat_i(dat), .dat_o(rd), .ack_o(ack), .idle_i(idle),
    .sleep_i(sleep), .ext_pin_i(pin), .irq_req_o(irq), .adc_trig_o(trig));
  gpt_pin_model pm (.clk_i(clk_i), .run_i(prun), .lvl_i(plvl), .pin_o(pin));
  always @(posedge clk_i) begin
    if (trig === 1'b1) trig_n++;
  end
  // ---
  // bus and check tasks
  // ---
  function automatic logic [7:0] ra(input int k, input int o);
    return 8'(k * 16 + o * 4);
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0000, d};
    // no local limit: only the watchdog may end a hung access
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rd;
    req <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic rng(input logic [31:0] lo, input logic [31:0] hi, input string nm);
    chk({31'h0, (r >= lo && r <= hi)}, 32'h1, nm);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    report_and_stop;
  end
  // ---
  // tests
  // ---
  initial begin
    logic [15:0] mk [5];
    int dv [4];
    logic [31:0] e;
    int t0;
    mk = '{`GPT_MASK_STANDALONE, `GPT_MASK_LOWER, `GPT_MASK_UPPER, `GPT_MASK_LOWER,
      `GPT_MASK_UPPER};
    dv = '{1, 8, 64, 256};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int k = 0; k < 5; k++) begin
      bus(0, ra(k, 0), 16'h0);
      chk(r, 32'h0, "ctl reset");
      bus(1, ra(k, 0), 16'hFFFF);
      bus(0, ra(k, 0), 16'h0);
      chk(r, {16'h0, mk[k]}, "ctl mask");
      bus(1, ra(k, 0), 16'h0);
    end
    bus(1, 8'h60, 16'hFFFF);
    bus(0, 8'h60, 16'h0);
    chk(r, 32'h0, "unmapped");
    $display("test regs done");
    for (int p = 0; p < 4; p++) begin
      bus(1, ra(0, 1), 16'h0);
      bus(1, ra(0, 2), 16'hFFFF);
      bus(1, ra(0, 0), 16'h8000 | 16'(p << 4));
      repeat (16 * dv[p]) @(posedge clk_i);
      bus(1, ra(0, 0), 16'h0);
      bus(0, ra(0, 1), 16'h0);
      rng(15, 19, "prescale");
    end
    e = r;
    repeat (20) @(posedge clk_i);
    bus(0, ra(0, 1), 16'h0);
    chk(r, e, "stopped");
    $display("test prescale done");
    bus(1, 8'h54, 16'h001F);
    bus(0, 8'h54, 16'h0);
    chk(r, 32'h1F, "irq enable");
    bus(1, 8'h50, 16'h001F);
    bus(1, ra(0, 1), 16'h0);
    bus(1, ra(0, 2), 16'h0003);
    bus(1, ra(0, 0), 16'h8000);
    repeat (20) @(posedge clk_i);
    bus(1, ra(0, 0), 16'h0);
    bus(0, ra(0, 1), 16'h0);
    rng(0, 3, "wrap");
    chk(irq[0], 1'b1, "match flag");
    bus(1, 8'h50, 16'h0001);
    chk(irq[0], 1'b0, "flag clear");
    $display("test period done");
    bus(1, ra(0, 1), 16'h0);
    bus(1, ra(0, 2), 16'hFFFF);
    idle <= 1'b1;
    bus(1, ra(0, 0), 16'hA000);
    repeat (30) @(posedge clk_i);
    bus(0, ra(0, 1), 16'h0);
    chk(r, 32'h0, "idle halt");
    bus(1, ra(0, 0), 16'h8000);
    repeat (30) @(posedge clk_i);
    bus(0, ra(0, 1), 16'h0);
    rng(25, 40, "idle run");
    idle <= 1'b0;
    bus(1, ra(0, 0), 16'h0);
    bus(1, ra(0, 1), 16'h0);
    bus(1, ra(0, 0), 16'h8040);
    plvl <= 5'h01;
    repeat (40) @(posedge clk_i);
    plvl <= 5'h00;
    repeat (10) @(posedge clk_i);
    bus(0, ra(0, 1), 16'h0);
    rng(36, 44, "gated count");
    chk(irq[0], 1'b1, "gate fall");
    bus(1, ra(0, 0), 16'h0);
    $display("test gate done");
    bus(1, ra(0, 1), 16'h0);
    sleep <= 1'b1;
    bus(1, ra(0, 0), 16'h8002);
    prun <= 5'h01;
    repeat (40) @(posedge clk_i);
    bus(0, ra(0, 1), 16'h0);
    rng(8, 12, "sleep async");
    bus(1, ra(0, 0), 16'h0);
    bus(1, ra(0, 1), 16'h0);
    bus(1, ra(0, 0), 16'h8006);
    repeat (40) @(posedge clk_i);
    bus(0, ra(0, 1), 16'h0);
    chk(r, 32'h0, "sleep sync");
    sleep <= 1'b0;
    prun <= 5'h00;
    bus(1, ra(0, 0), 16'h0);
    $display("test sleep done");
    bus(1, ra(1, 1), 16'h0);
    bus(1, ra(1, 2), 16'hFFFF);
    bus(1, ra(1, 0), 16'h8042);
    prun <= 5'h02;
    repeat (80) @(posedge clk_i);
    prun <= 5'h00;
    repeat (6) @(posedge clk_i);
    bus(0, ra(1, 1), 16'h0);
    rng(18, 21, "pin edges");
    bus(1, ra(1, 0), 16'h0);
    bus(1, 8'h50, 16'h001F);
    bus(1, ra(1, 1), 16'hFFF0);
    bus(1, ra(2, 1), 16'h0);
    bus(1, ra(1, 2), 16'h0010);
    bus(1, ra(2, 2), 16'h0001);
    bus(1, ra(2, 0), 16'h0042);
    bus(1, ra(1, 0), 16'h8008);
    repeat (20) @(posedge clk_i);
    bus(0, ra(2, 1), 16'h0);
    chk(r, 32'h1, "carry");
    repeat (30) @(posedge clk_i);
    bus(1, ra(1, 0), 16'h0);
    bus(0, 8'h50, 16'h0);
    chk(r & 32'h6, 32'h4, "wide flag");
    chk(irq[2], 1'b1, "wide irq");
    $display("test wide done");
    bus(1, ra(3, 1), 16'h0);
    bus(1, ra(3, 2), 16'h0003);
    bus(1, ra(3, 0), 16'h8000);
    t0 = trig_n;
    repeat (40) @(posedge clk_i);
    chk(trig_n - t0, 32'h0, "lower trig");
    bus(1, ra(3, 0), 16'h0);
    bus(1, ra(4, 2), 16'h0003);
    bus(1, ra(4, 0), 16'h8000);
    t0 = trig_n;
    repeat (40) @(posedge clk_i);
    r = trig_n - t0;
    rng(8, 11, "upper trig");
    bus(1, ra(4, 0), 16'h0);
    bus(1, ra(3, 1), 16'h0);
    bus(1, ra(4, 1), 16'h0);
    bus(1, ra(4, 2), 16'h0);
    bus(1, ra(3, 0), 16'h8008);
    t0 = trig_n;
    repeat (40) @(posedge clk_i);
    r = trig_n - t0;
    rng(8, 11, "wide trig");
    $display("test trigger done");
    report_and_stop;
  end
endmodule
